// file: logic/fpcc_pkg.sv
package fpcc_pkg;

	// register offsets on the plain register port (byte addresses)
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_ADDRESS = 8'h04;

	// field positions in the context control word
	localparam int BIT_LAZY = 0;
	localparam int BIT_PRIV = 1;
	localparam int BIT_SEC = 2;
	localparam int BIT_MODE = 3;
	localparam int BIT_HF = 4;

	// context address layout
	localparam int ADDR_LSB = 3;
	localparam logic [31:0] ADDR_RES_MASK = 32'h0000_0007;

	// reset values
	localparam logic RST_FLAG = 1'b0;
	localparam logic [28:0] RST_ADDR = 29'h0000_0000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// events the core reports on allocating a floating-point frame
	typedef struct packed {
		logic valid;
		logic secure;
		logic thread;
		logic unpriv;
		logic hf_pend_ok;
		logic [31:0] addr;
	} fpcc_alloc_type;

	// software access through the register port
	typedef struct packed {
		logic wr;
		logic rd;
		logic secure;
		logic [7:0] addr;
		logic [31:0] wdata;
	} fpcc_acc_type;

	// register access decode result, shared by both banks
	typedef enum logic [1:0] {
		FPCC_SEL_NONE = 2'b00,
		FPCC_SEL_CTRL = 2'b01,
		FPCC_SEL_ADDR = 2'b10
	} fpcc_sel_type;

endpackage

// file: logic/fpcc_bank.sv
// one security-state copy of the banked fields
module fpcc_bank (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic alloc_i,
	input wire logic thread_i,
	input wire logic unpriv_i,
	input wire logic [28:0] alloc_addr_i,
	input wire logic lazy_set_i,
	input wire logic lazy_clr_i,
	input wire logic sw_ctrl_wr_i,
	input wire logic sw_addr_wr_i,
	input wire logic [31:0] wdata_i,
	output logic mode_o,
	output logic priv_o,
	output logic lazy_o,
	output logic [28:0] addr_o
);

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			mode_o <= fpcc_pkg::RST_FLAG;
			priv_o <= fpcc_pkg::RST_FLAG;
		end else if (enable_i) begin
			if (alloc_i) begin
				mode_o <= thread_i;
				priv_o <= unpriv_i;
			end else if (sw_ctrl_wr_i) begin
				mode_o <= wdata_i[fpcc_pkg::BIT_MODE];
				priv_o <= wdata_i[fpcc_pkg::BIT_PRIV];
			end
		end
	end

	// hardware set wins over software or hardware clear
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			lazy_o <= fpcc_pkg::RST_FLAG;
		end else if (enable_i) begin
			if (lazy_set_i) begin
				lazy_o <= 1'b1;
			end else if (lazy_clr_i) begin
				lazy_o <= 1'b0;
			end else if (sw_ctrl_wr_i) begin
				lazy_o <= wdata_i[fpcc_pkg::BIT_LAZY];
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			addr_o <= fpcc_pkg::RST_ADDR;
		end else if (enable_i) begin
			if (alloc_i) begin
				addr_o <= alloc_addr_i;
			end else if (sw_addr_wr_i) begin
				addr_o <= wdata_i[31:fpcc_pkg::ADDR_LSB];
			end
		end
	end

endmodule

// file: logic/fpcc_regs.sv
////////////////////////////////////////////////////////////////////////////////
module fpcc_regs (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire fpcc_pkg::fpcc_alloc_type alloc_i,
	input wire logic lazy_activate_i,
	input wire logic lazy_done_i,
	input wire logic fp_instr_i,
	input wire logic cur_secure_i,
	input wire logic fault_target_nonsecure_cfg_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_secure_i,
	output logic [31:0] reg_rdata_o,
	output logic hard_fault_pend_ok_flag_o,
	output logic fp_context_secure_o,
	output logic lazy_preserve_active_flag_s_o,
	output logic lazy_preserve_active_flag_ns_o,
	output logic [31:0] fp_context_address_s_o,
	output logic [31:0] fp_context_address_ns_o
);

	////////////////////////////////////////////////////////////////////////////////
	// access decode

	fpcc_pkg::fpcc_sel_type sel;
	logic ctrl_wr_s;
	logic ctrl_wr_ns;
	logic addr_wr_s;
	logic addr_wr_ns;
	logic hf_visible;
	logic alloc_s;
	logic alloc_ns;
	logic lazy_set_s;
	logic lazy_set_ns;
	logic lazy_clr_s;
	logic lazy_clr_ns;

	always_comb begin
		case (reg_addr_i)
			fpcc_pkg::ADDR_CONTROL: begin
				sel = fpcc_pkg::FPCC_SEL_CTRL;
			end
			fpcc_pkg::ADDR_ADDRESS: begin
				sel = fpcc_pkg::FPCC_SEL_ADDR;
			end
			default: begin
				sel = fpcc_pkg::FPCC_SEL_NONE;
			end
		endcase
	end

	// bank chosen by the security state of the access
	assign ctrl_wr_s = reg_wr_i && reg_secure_i && (sel == fpcc_pkg::FPCC_SEL_CTRL);
	assign ctrl_wr_ns = reg_wr_i && !reg_secure_i && (sel == fpcc_pkg::FPCC_SEL_CTRL);
	assign addr_wr_s = reg_wr_i && reg_secure_i && (sel == fpcc_pkg::FPCC_SEL_ADDR);
	assign addr_wr_ns = reg_wr_i && !reg_secure_i && (sel == fpcc_pkg::FPCC_SEL_ADDR);

	// non-secure sees the ready bit only when faults target non-secure
	assign hf_visible = reg_secure_i || fault_target_nonsecure_cfg_i;

	// frame events land in the bank named by the frame's secure field, lazy events in the bank of the current state
	assign alloc_s = alloc_i.valid && alloc_i.secure;
	assign alloc_ns = alloc_i.valid && !alloc_i.secure;
	assign lazy_set_s = lazy_activate_i && cur_secure_i;
	assign lazy_set_ns = lazy_activate_i && !cur_secure_i;
	assign lazy_clr_s = lazy_done_i && cur_secure_i;
	assign lazy_clr_ns = lazy_done_i && !cur_secure_i;

	////////////////////////////////////////////////////////////////////////////////
	// banked copies

	logic mode_s;
	logic mode_ns;
	logic priv_s;
	logic priv_ns;
	logic [28:0] addr_s;
	logic [28:0] addr_ns;

	fpcc_bank u_bank_s (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.enable_i(enable_i),
		.alloc_i(alloc_s),
		.thread_i(alloc_i.thread),
		.unpriv_i(alloc_i.unpriv),
		.alloc_addr_i(alloc_i.addr[31:fpcc_pkg::ADDR_LSB]),
		.lazy_set_i(lazy_set_s),
		.lazy_clr_i(lazy_clr_s),
		.sw_ctrl_wr_i(ctrl_wr_s),
		.sw_addr_wr_i(addr_wr_s),
		.wdata_i(reg_wdata_i),
		.mode_o(mode_s),
		.priv_o(priv_s),
		.lazy_o(lazy_preserve_active_flag_s_o),
		.addr_o(addr_s)
	);

	fpcc_bank u_bank_ns (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.enable_i(enable_i),
		.alloc_i(alloc_ns),
		.thread_i(alloc_i.thread),
		.unpriv_i(alloc_i.unpriv),
		.alloc_addr_i(alloc_i.addr[31:fpcc_pkg::ADDR_LSB]),
		.lazy_set_i(lazy_set_ns),
		.lazy_clr_i(lazy_clr_ns),
		.sw_ctrl_wr_i(ctrl_wr_ns),
		.sw_addr_wr_i(addr_wr_ns),
		.wdata_i(reg_wdata_i),
		.mode_o(mode_ns),
		.priv_o(priv_ns),
		.lazy_o(lazy_preserve_active_flag_ns_o),
		.addr_o(addr_ns)
	);

	assign fp_context_address_s_o = {addr_s, 3'h0};
	assign fp_context_address_ns_o = {addr_ns, 3'h0};

	////////////////////////////////////////////////////////////////////////////////
	// shared fields

	// a single ready bit; secure sees it always, non-secure only when faults target non-secure
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			hard_fault_pend_ok_flag_o <= fpcc_pkg::RST_FLAG;
		end else if (enable_i) begin
			if (alloc_i.valid) begin
				hard_fault_pend_ok_flag_o <= alloc_i.hf_pend_ok;
			end else if (reg_wr_i && (sel == fpcc_pkg::FPCC_SEL_CTRL) && hf_visible) begin
				hard_fault_pend_ok_flag_o <= reg_wdata_i[fpcc_pkg::BIT_HF];
			end
		end
	end

	// hardware update outranks a software write in the same cycle
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			fp_context_secure_o <= fpcc_pkg::RST_FLAG;
		end else if (enable_i) begin
			if (lazy_activate_i || fp_instr_i) begin
				fp_context_secure_o <= cur_secure_i;
			end else if (ctrl_wr_s) begin
				fp_context_secure_o <= reg_wdata_i[fpcc_pkg::BIT_SEC];
			end
		end
	end

	// the mode copies drive nothing but the read path: no exception logic taps them

	////////////////////////////////////////////////////////////////////////////////
	// read path, data one cycle after the strobe

	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = fpcc_pkg::RD_ZERO;
		case (sel)
			fpcc_pkg::FPCC_SEL_CTRL: begin
				if (reg_secure_i) begin
					next_rdata[fpcc_pkg::BIT_MODE] = mode_s;
					next_rdata[fpcc_pkg::BIT_PRIV] = priv_s;
					next_rdata[fpcc_pkg::BIT_LAZY] = lazy_preserve_active_flag_s_o;
					next_rdata[fpcc_pkg::BIT_SEC] = fp_context_secure_o;
				end else begin
					next_rdata[fpcc_pkg::BIT_MODE] = mode_ns;
					next_rdata[fpcc_pkg::BIT_PRIV] = priv_ns;
					next_rdata[fpcc_pkg::BIT_LAZY] = lazy_preserve_active_flag_ns_o;
					next_rdata[fpcc_pkg::BIT_SEC] = 1'b0;
				end
				next_rdata[fpcc_pkg::BIT_HF] = hf_visible && hard_fault_pend_ok_flag_o;
			end
			fpcc_pkg::FPCC_SEL_ADDR: begin
				if (reg_secure_i) begin
					next_rdata = fp_context_address_s_o;
				end else begin
					next_rdata = fp_context_address_ns_o;
				end
				next_rdata = next_rdata & ~fpcc_pkg::ADDR_RES_MASK;
			end
			default: begin
				next_rdata = fpcc_pkg::RD_ZERO;
			end
		endcase
	end

	// zero outside the cycle after a read while enabled; with enable_i low it keeps its last value
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= fpcc_pkg::RD_ZERO;
		end else if (enable_i) begin
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end else begin
				reg_rdata_o <= fpcc_pkg::RD_ZERO;
			end
		end
	end

endmodule

// file: verification/fpcc_props.sv
module fpcc_props (
	input logic clk_sys_i,
	input logic reset_i,
	input logic enable_i,
	input fpcc_pkg::fpcc_alloc_type alloc_i,
	input logic lazy_activate_i,
	input logic lazy_done_i,
	input logic fp_instr_i,
	input logic cur_secure_i,
	input logic fault_target_nonsecure_cfg_i,
	input logic [7:0] reg_addr_i,
	input logic reg_wr_i,
	input logic reg_rd_i,
	input logic reg_secure_i,
	input logic [31:0] reg_rdata_o,
	input logic hard_fault_pend_ok_flag_o,
	input logic fp_context_secure_o,
	input logic lazy_preserve_active_flag_s_o,
	input logic lazy_preserve_active_flag_ns_o,
	input logic [31:0] fp_context_address_s_o,
	input logic [31:0] fp_context_address_ns_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_srd;
		enable_i && reg_rd_i && reg_secure_i && reg_addr_i == fpcc_pkg::ADDR_CONTROL;
	endsequence
	sequence s_nrd;
		enable_i && reg_rd_i && !reg_secure_i && reg_addr_i == fpcc_pkg::ADDR_CONTROL;
	endsequence
	a_hf_capture:
		assert property (enable_i && alloc_i.valid |=>
			hard_fault_pend_ok_flag_o == $past(alloc_i.hf_pend_ok)) else $error("ready not captured");
	a_addr_capture:
		assert property (enable_i && alloc_i.valid && alloc_i.secure |=>
			fp_context_address_s_o == ($past(alloc_i.addr) & 32'hffff_fff8)) else $error("bad address");
	a_addr_s_hold:
		assert property (!(reg_wr_i && reg_secure_i) && !(alloc_i.valid && alloc_i.secure) |=>
			$stable(fp_context_address_s_o)) else $error("secure address disturbed");
	a_addr_low_zero:
		assert property (fp_context_address_s_o[2:0] == 3'h0 && fp_context_address_ns_o[2:0] == 3'h0)
			else $error("address low bits set");
	a_ns_sec_hidden:
		assert property (s_nrd |=> !reg_rdata_o[fpcc_pkg::BIT_SEC]) else $error("secure bit seen");
	a_ns_hf_hidden:
		assert property (s_nrd ##0 !fault_target_nonsecure_cfg_i |=> !reg_rdata_o[fpcc_pkg::BIT_HF])
			else $error("ready bit seen");
	a_sec_rd_fields:
		assert property (s_srd |=> reg_rdata_o[31:5] == 27'h0
			&& reg_rdata_o[4] == $past(hard_fault_pend_ok_flag_o)
			&& reg_rdata_o[2] == $past(fp_context_secure_o)
			&& reg_rdata_o[0] == $past(lazy_preserve_active_flag_s_o)) else $error("bad control read");
	a_sec_track:
		assert property (enable_i && (lazy_activate_i || fp_instr_i) |=>
			fp_context_secure_o == $past(cur_secure_i)) else $error("owner not tracked");
	a_lazy_set:
		assert property (enable_i && lazy_activate_i && !cur_secure_i |=>
			lazy_preserve_active_flag_ns_o) else $error("lazy not set");
	a_lazy_clear:
		assert property (enable_i && lazy_done_i && !lazy_activate_i && cur_secure_i |=>
			!lazy_preserve_active_flag_s_o) else $error("lazy not cleared");
endmodule
bind fpcc_regs fpcc_props u_props (.*);

// file: verification/fp_context_capture_regs_tb.sv
module fp_context_capture_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
		$display("wrong value %s exp %h got %h", n, e, g); end end
	logic clk_sys_i = 0, reset_i = 1, la = 0, ld = 0, fi = 0, cs = 0, cfg = 0;
	logic wr = 0, rd = 0, rs = 0, en = 1;
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0, d, rdo;
	fpcc_pkg::fpcc_alloc_type al = '0;
	int mismatches = 0, samples_checked = 0, cyc = 0;
	fpcc_regs u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .enable_i(en), .alloc_i(al),
		.lazy_activate_i(la), .lazy_done_i(ld), .fp_instr_i(fi), .cur_secure_i(cs),
		.fault_target_nonsecure_cfg_i(cfg), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_secure_i(rs), .reg_rdata_o(rdo), .hard_fault_pend_ok_flag_o(),
		.fp_context_secure_o(), .lazy_preserve_active_flag_s_o(),
		.lazy_preserve_active_flag_ns_o(), .fp_context_address_s_o(),
		.fp_context_address_ns_o());
	always #12.5 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr_t(input logic [7:0] a, input logic [31:0] v, input logic s);
		@(posedge clk_sys_i);
		wr <= 1;
		ad <= a;
		wd <= v;
		rs <= s;
		@(posedge clk_sys_i);
		wr <= 0;
	endtask
	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd_t(input logic [7:0] a, input logic s);
		@(posedge clk_sys_i);
		rd <= 1;
		ad <= a;
		rs <= s;
		@(posedge clk_sys_i);
		rd <= 0;
		#1 d = rdo;
	endtask
	task automatic alc(input logic s, t, u, h, input logic [31:0] a);
		@(posedge clk_sys_i);
		al <= {1'b1, s, t, u, h, a};
		@(posedge clk_sys_i);
		al <= '0;
	endtask
	task automatic ev(input logic a, b, f, c);
		@(posedge clk_sys_i);
		la <= a;
		ld <= b;
		fi <= f;
		cs <= c;
		@(posedge clk_sys_i);
		la <= 0;
		ld <= 0;
		fi <= 0;
	endtask
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 0;
		rd_t(8'h00, 1);
		`CHK("ctrl rst", 32'h0, d)
		rd_t(8'h04, 1);
		`CHK("addr rst", 32'h0, d)
		$display("reset test done");
		alc(1, 1, 0, 1, 32'h2000_1237);
		rd_t(8'h00, 1);
		`CHK("ctrl s", 32'h18, d)
		rd_t(8'h04, 1);
		`CHK("addr s", 32'h2000_1230, d)
		rd_t(8'h04, 0);
		`CHK("addr ns", 32'h0, d)
		rd_t(8'h00, 0);
		`CHK("ctrl ns", 32'h0, d)
		$display("secure frame test done");
		alc(0, 0, 1, 0, 32'h0000_0ffc);
		cfg <= 1;
		rd_t(8'h00, 0);
		`CHK("ctrl ns", 32'h2, d)
		rd_t(8'h00, 1);
		`CHK("ctrl s", 32'h8, d)
		rd_t(8'h04, 0);
		`CHK("addr ns", 32'h0000_0ff8, d)
		$display("non-secure frame test done");
		ev(1, 0, 0, 1);
		rd_t(8'h00, 1);
		`CHK("ctrl s", 32'hd, d)
		rd_t(8'h00, 0);
		`CHK("ctrl ns", 32'h2, d)
		ev(0, 0, 1, 0);
		ev(0, 1, 0, 1);
		rd_t(8'h00, 1);
		`CHK("ctrl s", 32'h8, d)
		$display("lazy test done");
		cfg <= 0;
		wr_t(8'h00, 32'hff, 0);
		cfg <= 1;
		rd_t(8'h00, 0);
		`CHK("ctrl ns", 32'hb, d)
		rd_t(8'h00, 1);
		`CHK("ctrl s", 32'h8, d)
		wr_t(8'h04, 32'hffff_ffff, 0);
		rd_t(8'h04, 0);
		`CHK("addr ns", 32'hffff_fff8, d)
		rd_t(8'h04, 1);
		`CHK("addr s", 32'h2000_1230, d)
		wr_t(8'h08, 32'hffff_ffff, 1);
		rd_t(8'h08, 1);
		`CHK("unmapped", 32'h0, d)
		$display("write test done");
		// non-secure lazy activation lands in the non-secure bank only
		wr_t(8'h00, 32'h0, 0);
		ev(1, 0, 0, 0);
		rd_t(8'h00, 0);
		`CHK("ctrl ns lazy", 32'h1, d)
		rd_t(8'h00, 1);
		`CHK("ctrl s lazy", 32'h8, d)
		// a frame offered while the clock enable is low must leave no trace
		en <= 0;
		alc(1, 0, 0, 0, 32'h0000_0040);
		en <= 1;
		rd_t(8'h04, 1);
		`CHK("addr frozen", 32'h2000_1230, d)
		rd_t(8'h00, 1);
		`CHK("ctrl frozen", 32'h8, d)
		$display("lazy bank and enable test done");
		finish_test();
	end
endmodule
